// ---- shared/acp_pkg.sv ----
// Constants, field layouts and carrier types for the comparator pair control block.
// Assumes one system clock domain; the analog comparators sit outside and deliver raw levels.
package acp_pkg;
   // ==================================================================
   // Register offsets.
   localparam logic [7:0] ACP_OFF_CMP0_CFG = 8'h00;
   localparam logic [7:0] ACP_OFF_CMP1_CFG = 8'h01;
   localparam logic [7:0] ACP_OFF_CMP0_NEG = 8'h02;
   localparam logic [7:0] ACP_OFF_CMP1_NEG = 8'h03;
   localparam logic [7:0] ACP_OFF_ROUTE = 8'h04;
   localparam logic [7:0] ACP_OFF_SCALER = 8'h05;
   localparam logic [7:0] ACP_OFF_WINDOW = 8'h06;
   localparam logic [7:0] ACP_OFF_STATUS = 8'h07;
   localparam logic [7:0] ACP_OFF_CURRENT = 8'h08;
   localparam logic [7:0] ACP_OFF_TRIM = 8'h09;
   // ==================================================================
   // Field positions.
   localparam int ACP_CFG_MODE_LSB = 6;
   localparam int ACP_CFG_LEVEL_LSB = 4;
   localparam int ACP_WIN_EN_BIT = 4;
   localparam int ACP_WIN_MODE_LSB = 2;
   localparam int ACP_WIN_LEVEL_LSB = 0;
   localparam int ACP_ST_POS_LSB = 6;
   localparam int ACP_ST_LVL1_BIT = 5;
   localparam int ACP_ST_LVL0_BIT = 4;
   localparam int ACP_FLAG_WIN = 2;
   localparam int ACP_FLAG_CMP1 = 1;
   localparam int ACP_FLAG_CMP0 = 0;
   localparam int ACP_CUR_EN_BIT = 7;
   // Writable-bit masks; reserved bits are dropped and read as zero.
   localparam logic [7:0] ACP_MASK_CFG = 8'hf0;
   localparam logic [7:0] ACP_MASK_NEG = 8'h07;
   localparam logic [7:0] ACP_MASK_ROUTE = 8'h03;
   localparam logic [7:0] ACP_MASK_SCALER = 8'h3f;
   localparam logic [7:0] ACP_MASK_WINDOW = 8'h1f;
   localparam logic [7:0] ACP_MASK_CURRENT = 8'h83;
   localparam logic [7:0] ACP_MASK_TRIM = 8'h0f;
   localparam logic [7:0] ACP_REG_RST = 8'h00;
   localparam int ACP_SYNC_STAGES = 3;
   // ==================================================================
   // Encodings.
   typedef enum logic [1:0] {ACP_EDGE_BOTH, ACP_EDGE_RSVD, ACP_EDGE_FALL, ACP_EDGE_RISE} acp_edge_e;
   typedef enum logic [1:0] {ACP_WIN_ABOVE, ACP_WIN_INSIDE, ACP_WIN_BELOW, ACP_WIN_OUTSIDE} acp_win_e;
   localparam logic [2:0] ACP_NEG_BANDGAP = 3'h6;
   localparam logic [2:0] ACP_NEG_SCALER = 3'h7;
   localparam logic [2:0] ACP_NEG_RSVD = 3'h5;
   // Decoded negative-input selection.
   typedef struct packed {
      logic [7:0] pin;
      logic bandgap;
      logic scaler;
   } acp_neg_s;
   // Pin drive for a comparator output.
   typedef struct packed {
      logic oe;
      logic val;
   } acp_pin_s;
endpackage : acp_pkg

// ---- design/acp_top.sv ----
// Control and status logic for a pair of analog comparators on one port.
// Assumes raw comparator levels arrive asynchronously and that bus strobes are one cycle long.
//
// Functional notes
// - Negative select decodes 000..100 to pins 0,1,3,5,7; 110 bandgap, 111 scaler; 101 reserved.
// - Pin drive bit one puts comparator one's result on port pin 6.
// - Pin drive bit zero puts comparator zero's result on port pin 7.
// - Six-bit scaler code sets scaler level to supply times code plus one over 64.
// - Window enable makes both comparators work together as a window comparator.
// - Window mode picks the flag condition: above, inside, below, outside.
// - Nonzero window level enables the window interrupt and sets its priority.
// - While window mode is on, the position field reports above, inside or below.
// - Status bits 5 and 4 show the present levels of comparators one and zero.
// - Window flag sets when the condition chosen by the window mode occurs.
// - Window flag clears when its interrupt vector is serviced.
// - Writing one to a flag clears it; writing zero leaves it.
// - Each comparator flag sets when its output edge matches its edge mode.
// - Comparator one flag clears when its interrupt vector is serviced.
// - Comparator zero flag clears when its interrupt vector is serviced.
// - Current control bit 7 switches the constant current source on.
// - Comparator one route bit sends current to comparator one's selected pin.
// - Comparator zero route bit sends current to comparator zero's selected pin.
// - Edge mode: 00 either edge, 01 reserved, 10 falling, 11 rising.
// - A comparator result is one when its positive input exceeds its negative.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module acp_top
   import acp_pkg::*;
#(
   parameter int ADDR_W = 8 // Register address width.
) (
   input wire logic sys_clk, // System clock, 250 MHz.
   input wire logic resetn, // Asynchronous reset, active low.
   input wire logic [ADDR_W-1:0] reg_addr, // Register address.
   input wire logic [7:0] reg_wdata, // Write data.
   input wire logic reg_wr, // Write strobe.
   input wire logic reg_rd, // Read strobe.
   output logic [7:0] reg_rdata, // Read data, valid the cycle after a read.
   input wire logic cmp0_raw, // Comparator zero analog result.
   input wire logic cmp1_raw, // Comparator one analog result.
   input wire logic cmp0_vec_ack, // Comparator zero vector serviced pulse.
   input wire logic cmp1_vec_ack, // Comparator one vector serviced pulse.
   input wire logic win_vec_ack, // Window vector serviced pulse.
   output acp_pin_s pin6_drive, // Comparator one output on port pin 6.
   output acp_pin_s pin7_drive, // Comparator zero output on port pin 7.
   output acp_neg_s cmp0_neg_sel, // Comparator zero negative input.
   output acp_neg_s cmp1_neg_sel, // Comparator one negative input.
   output logic [5:0] scaler_code, // Supply scaler code.
   output logic [6:0] scaler_steps, // Scaler numerator, code plus one.
   output logic window_enable, // Window mode on.
   output logic current_on, // Constant current source on.
   output logic [7:0] current_pin_en, // Pins receiving the current source.
   output logic [3:0] current_trim, // Current source trim.
   output logic irq_cmp0, // Comparator zero interrupt request.
   output logic irq_cmp1, // Comparator one interrupt request.
   output logic irq_window, // Window interrupt request.
   output logic [1:0] irq_cmp0_level, // Comparator zero priority level.
   output logic [1:0] irq_cmp1_level, // Comparator one priority level.
   output logic [1:0] irq_window_level // Window priority level.
);
   // ==================================================================
   // Elaboration checks.
   if (ADDR_W < 4) begin : g_bad_addr
      $error("acp_top: ADDR_W must be at least 4");
   end

   // ==================================================================
   // State.
   typedef struct packed {
      logic [7:0] cfg0;
      logic [7:0] cfg1;
      logic [2:0] neg0;
      logic [2:0] neg1;
      logic [1:0] route;
      logic [5:0] scaler;
      logic [4:0] winctl;
      logic [2:0] flags;
      logic [7:0] curctl;
      logic [3:0] trim;
      logic [ACP_SYNC_STAGES-1:0] sync0;
      logic [ACP_SYNC_STAGES-1:0] sync1;
      logic lvl0;
      logic lvl1;
      logic [1:0] pos;
      logic [7:0] rdata;
      acp_pin_s pin6;
      acp_pin_s pin7;
      acp_neg_s dec0;
      acp_neg_s dec1;
      logic [6:0] steps;
      logic [7:0] cur_pins;
      logic [2:0] irq;
   } acp_state_s;

   acp_state_s st_reg;
   acp_state_s st_next;

   // ==================================================================
   // Helpers.
   // Negative input decode, used for both comparators.
   function automatic acp_neg_s acp_decode_neg(input logic [2:0] sel);
      acp_neg_s d;
      d = '0;
      case (sel)
         3'h0: d.pin = 8'h01;
         3'h1: d.pin = 8'h02;
         3'h2: d.pin = 8'h08;
         3'h3: d.pin = 8'h20;
         3'h4: d.pin = 8'h80;
         ACP_NEG_BANDGAP: d.bandgap = 1'b1;
         ACP_NEG_SCALER: d.scaler = 1'b1;
         default: d = '0;
      endcase
      return d;
   endfunction : acp_decode_neg

   // Edge match against a comparator's edge mode.
   function automatic logic acp_edge_hit(input logic [1:0] mode, input logic old_l,
                                         input logic new_l);
      logic hit;
      hit = 1'b0;
      case (acp_edge_e'(mode))
         ACP_EDGE_BOTH: hit = old_l != new_l;
         ACP_EDGE_FALL: hit = old_l && !new_l;
         ACP_EDGE_RISE: hit = !old_l && new_l;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : acp_edge_hit

   // Window position: comparator zero watches the top threshold, one the bottom.
   function automatic logic [1:0] acp_position(input logic l0, input logic l1);
      logic [1:0] p;
      p = ACP_WIN_BELOW;
      if (l0) begin
         p = ACP_WIN_ABOVE;
      end else if (l1) begin
         p = ACP_WIN_INSIDE;
      end
      return p;
   endfunction : acp_position

   // Address match at the bus width.
   function automatic logic acp_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      return a == ADDR_W'(off);
   endfunction : acp_hit

   // ==================================================================
   // Next-state logic.
   // Levels are accepted only once the last two synchroniser stages agree, so a glitch
   // shorter than a clock never makes an edge; the trade is three to four cycles of latency.
   always_comb begin
      logic [2:0] set_f;
      logic [2:0] clr_f;
      logic [1:0] pos_new;
      logic win_on;
      logic win_hit;
      logic st_wr;
      set_f = '0;
      clr_f = '0;
      pos_new = '0;
      win_on = 1'b0;
      win_hit = 1'b0;
      st_wr = 1'b0;
      st_next = st_reg;

      // Synchronisers and stable levels.
      st_next.sync0 = {st_reg.sync0[ACP_SYNC_STAGES-2:0], cmp0_raw};
      st_next.sync1 = {st_reg.sync1[ACP_SYNC_STAGES-2:0], cmp1_raw};
      if (st_reg.sync0[2] == st_reg.sync0[1]) begin
         st_next.lvl0 = st_reg.sync0[2];
      end
      if (st_reg.sync1[2] == st_reg.sync1[1]) begin
         st_next.lvl1 = st_reg.sync1[2];
      end

      // Register writes; reserved bits are masked off.
      if (reg_wr) begin
         if (acp_hit(reg_addr, ACP_OFF_CMP0_CFG)) begin
            st_next.cfg0 = reg_wdata & ACP_MASK_CFG;
         end
         if (acp_hit(reg_addr, ACP_OFF_CMP1_CFG)) begin
            st_next.cfg1 = reg_wdata & ACP_MASK_CFG;
         end
         if (acp_hit(reg_addr, ACP_OFF_CMP0_NEG)) begin
            st_next.neg0 = reg_wdata[2:0];
         end
         if (acp_hit(reg_addr, ACP_OFF_CMP1_NEG)) begin
            st_next.neg1 = reg_wdata[2:0];
         end
         if (acp_hit(reg_addr, ACP_OFF_ROUTE)) begin
            st_next.route = reg_wdata[1:0];
         end
         if (acp_hit(reg_addr, ACP_OFF_SCALER)) begin
            st_next.scaler = reg_wdata[5:0];
         end
         if (acp_hit(reg_addr, ACP_OFF_WINDOW)) begin
            st_next.winctl = reg_wdata[4:0];
         end
         if (acp_hit(reg_addr, ACP_OFF_CURRENT)) begin
            st_next.curctl = reg_wdata & ACP_MASK_CURRENT;
         end
         if (acp_hit(reg_addr, ACP_OFF_TRIM)) begin
            st_next.trim = reg_wdata[3:0];
         end
         st_wr = acp_hit(reg_addr, ACP_OFF_STATUS);
      end

      // Edge flags.
      set_f[ACP_FLAG_CMP0] = acp_edge_hit(st_reg.cfg0[7:6], st_reg.lvl0, st_next.lvl0);
      set_f[ACP_FLAG_CMP1] = acp_edge_hit(st_reg.cfg1[7:6], st_reg.lvl1, st_next.lvl1);

      // Window condition is an entry event into the chosen region.
      win_on = st_reg.winctl[ACP_WIN_EN_BIT];
      pos_new = acp_position(st_next.lvl0, st_next.lvl1);
      st_next.pos = pos_new;
      if (pos_new != st_reg.pos) begin
         case (acp_win_e'(st_reg.winctl[3:2]))
            ACP_WIN_ABOVE: win_hit = pos_new == ACP_WIN_ABOVE;
            ACP_WIN_INSIDE: win_hit = pos_new == ACP_WIN_INSIDE;
            ACP_WIN_BELOW: win_hit = pos_new == ACP_WIN_BELOW;
            ACP_WIN_OUTSIDE: win_hit = st_reg.pos == ACP_WIN_INSIDE;
            default: win_hit = 1'b0;
         endcase
      end
      set_f[ACP_FLAG_WIN] = win_on && win_hit;

      // Clears by write-one or vector service; a set in the same cycle wins.
      clr_f = st_wr ? reg_wdata[2:0] : 3'h0;
      clr_f[ACP_FLAG_CMP0] = clr_f[ACP_FLAG_CMP0] | cmp0_vec_ack;
      clr_f[ACP_FLAG_CMP1] = clr_f[ACP_FLAG_CMP1] | cmp1_vec_ack;
      clr_f[ACP_FLAG_WIN] = clr_f[ACP_FLAG_WIN] | win_vec_ack;
      st_next.flags = (st_reg.flags & ~clr_f) | set_f;

      // Read data stands only in the cycle after the read strobe.
      st_next.rdata = 8'h00;
      if (reg_rd) begin
         if (acp_hit(reg_addr, ACP_OFF_CMP0_CFG)) begin
            st_next.rdata = st_reg.cfg0;
         end
         if (acp_hit(reg_addr, ACP_OFF_CMP1_CFG)) begin
            st_next.rdata = st_reg.cfg1;
         end
         if (acp_hit(reg_addr, ACP_OFF_CMP0_NEG)) begin
            st_next.rdata = {5'h00, st_reg.neg0};
         end
         if (acp_hit(reg_addr, ACP_OFF_CMP1_NEG)) begin
            st_next.rdata = {5'h00, st_reg.neg1};
         end
         if (acp_hit(reg_addr, ACP_OFF_ROUTE)) begin
            st_next.rdata = {6'h00, st_reg.route};
         end
         if (acp_hit(reg_addr, ACP_OFF_SCALER)) begin
            st_next.rdata = {2'h0, st_reg.scaler};
         end
         if (acp_hit(reg_addr, ACP_OFF_WINDOW)) begin
            st_next.rdata = {3'h0, st_reg.winctl};
         end
         if (acp_hit(reg_addr, ACP_OFF_STATUS)) begin
            st_next.rdata = {win_on ? st_reg.pos : 2'h0,
                             st_reg.lvl1, st_reg.lvl0, 1'b0, st_reg.flags};
         end
         if (acp_hit(reg_addr, ACP_OFF_CURRENT)) begin
            st_next.rdata = st_reg.curctl;
         end
         if (acp_hit(reg_addr, ACP_OFF_TRIM)) begin
            st_next.rdata = {4'h0, st_reg.trim};
         end
      end

      // Registered outputs, built from the next register values.
      st_next.pin6 = '{oe: st_next.route[1], val: st_next.lvl1};
      st_next.pin7 = '{oe: st_next.route[0], val: st_next.lvl0};
      st_next.dec0 = acp_decode_neg(st_next.neg0);
      st_next.dec1 = acp_decode_neg(st_next.neg1);
      st_next.steps = {1'b0, st_next.scaler} + 7'h01;
      st_next.cur_pins = 8'h00;
      if (st_next.curctl[ACP_CUR_EN_BIT]) begin
         if (st_next.curctl[0]) begin
            st_next.cur_pins = st_next.cur_pins | st_next.dec0.pin;
         end
         if (st_next.curctl[1]) begin
            st_next.cur_pins = st_next.cur_pins | st_next.dec1.pin;
         end
      end
      st_next.irq[ACP_FLAG_CMP0] = st_next.flags[ACP_FLAG_CMP0] && (st_next.cfg0[5:4] != 2'h0);
      st_next.irq[ACP_FLAG_CMP1] = st_next.flags[ACP_FLAG_CMP1] && (st_next.cfg1[5:4] != 2'h0);
      st_next.irq[ACP_FLAG_WIN] = st_next.flags[ACP_FLAG_WIN] && (st_next.winctl[1:0] != 2'h0);
   end

   // ==================================================================
   // State register; everything clears on reset.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==================================================================
   // Output wiring straight from the state register.
   assign reg_rdata = st_reg.rdata;
   assign pin6_drive = st_reg.pin6;
   assign pin7_drive = st_reg.pin7;
   assign cmp0_neg_sel = st_reg.dec0;
   assign cmp1_neg_sel = st_reg.dec1;
   assign scaler_code = st_reg.scaler;
   assign scaler_steps = st_reg.steps;
   assign window_enable = st_reg.winctl[ACP_WIN_EN_BIT];
   assign current_on = st_reg.curctl[ACP_CUR_EN_BIT];
   assign current_pin_en = st_reg.cur_pins;
   assign current_trim = st_reg.trim;
   assign irq_cmp0 = st_reg.irq[ACP_FLAG_CMP0];
   assign irq_cmp1 = st_reg.irq[ACP_FLAG_CMP1];
   assign irq_window = st_reg.irq[ACP_FLAG_WIN];
   assign irq_cmp0_level = st_reg.cfg0[5:4];
   assign irq_cmp1_level = st_reg.cfg1[5:4];
   assign irq_window_level = st_reg.winctl[1:0];

   // ==================================================================
   // Assertions.
   default clocking acp_cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   a_read_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero after idle cycle");
   a_pin6_route: assert property (reg_wr && acp_hit(reg_addr, ACP_OFF_ROUTE) && reg_wdata[1]
                                  |=> pin6_drive.oe && pin6_drive.val == st_reg.lvl1)
      else $error("pin 6 not driven by comparator one");
   a_pin7_route: assert property (pin7_drive.oe |-> pin7_drive.val == st_reg.lvl0)
      else $error("pin 7 value differs from comparator zero");
   a_neg_bandgap: assert property (reg_wr && acp_hit(reg_addr, ACP_OFF_CMP0_NEG)
                                   && reg_wdata[2:0] == ACP_NEG_BANDGAP
                                   |=> cmp0_neg_sel.bandgap && cmp0_neg_sel.pin == 8'h00)
      else $error("bandgap selection not decoded");
   a_neg_reserved: assert property (st_reg.neg1 == ACP_NEG_RSVD |-> cmp1_neg_sel == '0)
      else $error("reserved selection drives an input");
   a_scaler_steps: assert property (reg_wr && acp_hit(reg_addr, ACP_OFF_SCALER)
                                    |=> scaler_steps == {1'b0, $past(reg_wdata[5:0])} + 7'h01)
      else $error("scaler steps not code plus one");
   a_win_flag_cause: assert property ($rose(st_reg.flags[ACP_FLAG_WIN])
                                      |-> $past(st_reg.winctl[ACP_WIN_EN_BIT]))
      else $error("window flag set outside window mode");
   a_edge_rise: assert property (st_reg.cfg0[7:6] == 2'h3 && !st_reg.lvl0 && st_next.lvl0
                                 |=> st_reg.flags[ACP_FLAG_CMP0])
      else $error("rising edge did not set comparator zero flag");
   a_w1c_clear: assert property (reg_wr && acp_hit(reg_addr, ACP_OFF_STATUS) && reg_wdata[0]
                                 && st_next.lvl0 == st_reg.lvl0
                                 |=> !st_reg.flags[ACP_FLAG_CMP0])
      else $error("write one did not clear comparator zero flag");
   a_ack_clear: assert property (cmp1_vec_ack && st_next.lvl1 == st_reg.lvl1
                                 |=> !st_reg.flags[ACP_FLAG_CMP1])
      else $error("vector service did not clear comparator one flag");
   a_window_pos_off: assert property (reg_rd && acp_hit(reg_addr, ACP_OFF_STATUS)
                                      && !st_reg.winctl[ACP_WIN_EN_BIT]
                                      |=> reg_rdata[7:6] == 2'h0)
      else $error("window position shown while window mode off");
   a_sync_settle: assert property ($changed(st_reg.lvl0)
                                   |-> $past(st_reg.sync0[2]) == $past(st_reg.sync0[1]))
      else $error("level changed before synchroniser settled");
   a_irq_needs_flag: assert property (irq_window |-> st_reg.flags[ACP_FLAG_WIN]
                                      && irq_window_level != 2'h0)
      else $error("window request without flag and level");
   a_current_gate: assert property (current_pin_en != 8'h00 |-> current_on)
      else $error("current routed while source off");
endmodule : acp_top
`default_nettype wire

// ---- sim/acp_top_tb.sv ----
// Self-checking bench for the comparator pair control block.
// Assumes the block's default address width and one 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module acp_top_tb;
   import acp_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic cmp0_raw = 1'b0;
   logic cmp1_raw = 1'b0;
   logic cmp0_vec_ack = 1'b0;
   logic cmp1_vec_ack = 1'b0;
   logic win_vec_ack = 1'b0;
   acp_pin_s pin6_drive, pin7_drive;
   acp_neg_s cmp0_neg_sel, cmp1_neg_sel;
   logic [5:0] scaler_code;
   logic [6:0] scaler_steps;
   logic window_enable, current_on, irq_cmp0, irq_cmp1, irq_window;
   logic [7:0] current_pin_en;
   logic [3:0] current_trim;
   logic [1:0] irq_cmp0_level, irq_cmp1_level, irq_window_level;
   int failures = 0;
   int checks_done = 0;
   logic [9:0] neg_exp [8];
   // ================================================================
   // Clock at a 4 ns period.
   always #2 sys_clk = ~sys_clk;
   acp_top acp_top_inst (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cmp0_raw(cmp0_raw), .cmp1_raw(cmp1_raw), .cmp0_vec_ack(cmp0_vec_ack),
      .cmp1_vec_ack(cmp1_vec_ack), .win_vec_ack(win_vec_ack), .pin6_drive(pin6_drive),
      .pin7_drive(pin7_drive), .cmp0_neg_sel(cmp0_neg_sel), .cmp1_neg_sel(cmp1_neg_sel),
      .scaler_code(scaler_code), .scaler_steps(scaler_steps), .window_enable(window_enable),
      .current_on(current_on), .current_pin_en(current_pin_en), .current_trim(current_trim),
      .irq_cmp0(irq_cmp0), .irq_cmp1(irq_cmp1), .irq_window(irq_window),
      .irq_cmp0_level(irq_cmp0_level), .irq_cmp1_level(irq_cmp1_level),
      .irq_window_level(irq_window_level));
   // ================================================================
   // Shared tasks; every strobe is set after an edge and dropped at the next one.
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   // Read data only stand in the cycle after the strobe, so they are sampled there.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk({2'b00, reg_rdata}, {2'b00, exp}, "register read");
   endtask : rd
   // Raw levels change at an edge; the synchroniser needs up to four cycles, six leave margin.
   task automatic settle(input logic [1:0] raw);
      @(posedge sys_clk);
      {cmp1_raw, cmp0_raw} <= raw;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask : settle
   task automatic pulse(input int which);
      @(posedge sys_clk);
      if (which == 0) begin
         cmp0_vec_ack <= 1'b1;
      end else if (which == 1) begin
         cmp1_vec_ack <= 1'b1;
      end else begin
         win_vec_ack <= 1'b1;
      end
      @(posedge sys_clk);
      {cmp0_vec_ack, cmp1_vec_ack, win_vec_ack} <= 3'b000;
      #1;
   endtask : pulse
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   // ================================================================
   // Watchdog: the tests need well under a thousand cycles.
   initial begin
      #20000;
      failures++;
      print_verdict();
   end
   // ================================================================
   // Main sequence.
   initial begin
      neg_exp = '{10'h004, 10'h008, 10'h020, 10'h080, 10'h200, 10'h000, 10'h002, 10'h001};
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int a = 4; a < 10; a++) rd(a[7:0], 8'h00);
      rd(8'h0a, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) if (i != 5) begin
         wr(ACP_OFF_CMP0_NEG, i[7:0]);
         chk(cmp0_neg_sel, neg_exp[i], "negative select");
      end
      $display("test negative select done");
      wr(ACP_OFF_ROUTE, 8'h03);
      settle(2'b10);
      chk({8'h00, pin6_drive}, 10'h003, "pin 6 drive");
      chk({8'h00, pin7_drive}, 10'h002, "pin 7 drive");
      rd(ACP_OFF_STATUS, 8'h22);
      wr(ACP_OFF_STATUS, 8'h07);
      rd(ACP_OFF_STATUS, 8'h20);
      $display("test pin drive done");
      wr(ACP_OFF_CMP0_CFG, 8'hd0);
      settle(2'b11);
      chk({9'h000, irq_cmp0}, 10'h001, "cmp0 irq");
      rd(ACP_OFF_STATUS, 8'h31);
      pulse(0);
      rd(ACP_OFF_STATUS, 8'h30);
      wr(ACP_OFF_CMP0_CFG, 8'h90);
      settle(2'b10);
      rd(ACP_OFF_STATUS, 8'h21);
      wr(ACP_OFF_STATUS, 8'h01);
      wr(ACP_OFF_CMP0_CFG, 8'h50);
      settle(2'b11);
      rd(ACP_OFF_STATUS, 8'h30);
      $display("test edge flags done");
      wr(ACP_OFF_CMP1_CFG, 8'hd0);
      settle(2'b00);
      wr(ACP_OFF_STATUS, 8'h07);
      wr(ACP_OFF_WINDOW, 8'h15);
      chk({9'h000, window_enable}, 10'h001, "window enable");
      rd(ACP_OFF_STATUS, 8'h80);
      settle(2'b10);
      chk({8'h00, irq_window, irq_cmp1}, 10'h003, "window and cmp1 irq");
      chk({4'h0, irq_cmp0_level, irq_cmp1_level, irq_window_level}, 10'h015, "irq levels");
      rd(ACP_OFF_STATUS, 8'h66);
      pulse(2);
      rd(ACP_OFF_STATUS, 8'h62);
      pulse(1);
      rd(ACP_OFF_STATUS, 8'h60);
      wr(ACP_OFF_WINDOW, 8'h11);
      settle(2'b11);
      rd(ACP_OFF_STATUS, 8'h34);
      wr(ACP_OFF_STATUS, 8'h00);
      rd(ACP_OFF_STATUS, 8'h34);
      wr(ACP_OFF_STATUS, 8'h07);
      wr(ACP_OFF_WINDOW, 8'h19);
      settle(2'b00);
      rd(ACP_OFF_STATUS, 8'h84);
      wr(ACP_OFF_STATUS, 8'h07);
      wr(ACP_OFF_WINDOW, 8'h1d);
      settle(2'b10);
      rd(ACP_OFF_STATUS, 8'h62);
      settle(2'b00);
      rd(ACP_OFF_STATUS, 8'h86);
      $display("test window done");
      wr(ACP_OFF_SCALER, 8'h3f);
      chk({3'b000, scaler_steps}, 10'h040, "scaler steps");
      chk({4'h0, scaler_code}, 10'h03f, "scaler code");
      rd(ACP_OFF_SCALER, 8'h3f);
      wr(ACP_OFF_CMP1_NEG, 8'h05);
      chk(cmp1_neg_sel, 10'h000, "reserved select");
      wr(ACP_OFF_CMP0_NEG, 8'h01);
      wr(ACP_OFF_CMP1_NEG, 8'h03);
      wr(ACP_OFF_CURRENT, 8'h83);
      chk({1'b0, current_on, current_pin_en}, 10'h122, "current routing");
      wr(ACP_OFF_TRIM, 8'h0f);
      chk({6'h00, current_trim}, 10'h00f, "current trim");
      rd(ACP_OFF_TRIM, 8'h0f);
      $display("test current source done");
      print_verdict();
   end
endmodule : acp_top_tb
`default_nettype wire
